//--- src/txr_regs.sv
// register bank: transmit lead time, beacon and normal send control
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module txr_regs #(
    parameter int MAX_RETRIES = 3
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // transmit engine
    input  wire logic        packet_due,
    input  wire logic        tx_done,
    input  wire logic        ack_seen,
    input  wire logic        ack_frame_pending,
    output logic             beacon_send,
    output logic             normal_send,
    output txr_pkg::txr_frame_opt_type normal_opts,
    output logic             beacon_secure,
    output logic             tx_enable,
    output logic             queue_enable
);
    if (MAX_RETRIES < 0 || MAX_RETRIES > 15) begin : g_bad_retries
        $error("MAX_RETRIES out of range");
    end

    txr_pkg::txr_lead_type lead_r;
    logic       bsec_r;
    logic       btrig_r;
    logic       ntrig_r;
    logic [6:0] sh_other_r;
    logic       fp_r;
    txr_pkg::txr_frame_opt_type nopt_r;
    logic [3:0] retry_r;
    logic       awaiting_ack_r;
    logic       resend_r;
    logic [19:0] lead_cnt_r;
    logic        txen_r;

    wire wr_en   = psel & penable & pwrite;
    wire hit_on  = paddr == txr_pkg::ADDR_ON_TIME;
    wire hit_sh  = paddr == txr_pkg::ADDR_SYMTICK_HIGH;
    wire hit_bc  = paddr == txr_pkg::ADDR_BEACON;
    wire hit_nc  = paddr == txr_pkg::ADDR_NORMAL;
    wire hit_st  = paddr == txr_pkg::ADDR_STATUS;
    wire mapped  = hit_on | hit_sh | hit_bc | hit_nc | hit_st;
    wire wr_on   = wr_en & hit_on;
    wire wr_sh   = wr_en & hit_sh;
    wire wr_bc   = wr_en & hit_bc;
    wire wr_nc   = wr_en & hit_nc;
    wire new_ntrig = wr_nc & pwdata[txr_pkg::TRIG_BIT];
    wire [3:0] sym_wr = pwdata[txr_pkg::ON_SYM_LSB +: 4];
    // keep field legal: zero is clamped to the minimum
    wire [3:0] sym_legal = (sym_wr < txr_pkg::SYM_MIN) ? txr_pkg::SYM_MIN : sym_wr;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire [7:0] rd_on = {lead_r.queue_enable, 1'b0, lead_r.tx_lead_symbols,
                        lead_r.tx_lead_ticks[8:7]};
    wire [7:0] rd_sh = {lead_r.tx_lead_ticks[6:0], sh_other_r[0]};
    wire [7:0] rd_bc = {6'h00, bsec_r, 1'b0};
    wire [7:0] rd_nc = {3'h0, fp_r, nopt_r.ind, nopt_r.ack, nopt_r.sec, 1'b0};
    wire [7:0] rd_st = {3'h0, retry_r, awaiting_ack_r};
    wire [7:0] rd_sel = hit_on ? rd_on : hit_sh ? rd_sh : hit_bc ? rd_bc :
                        hit_nc ? rd_nc : hit_st ? rd_st : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, rd_sel};
        end
    end

    // lead-time configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lead_r.queue_enable    <= 1'b1;
            lead_r.tx_lead_symbols <= txr_pkg::SYM_RESET;
            lead_r.tx_lead_ticks   <= txr_pkg::TICK_RESET;
            sh_other_r             <= 7'h00;
        end else begin
            if (wr_on) begin
                lead_r.queue_enable       <= pwdata[txr_pkg::ON_QEN_BIT];
                lead_r.tx_lead_symbols    <= sym_legal;
                lead_r.tx_lead_ticks[8:7] <= pwdata[txr_pkg::ON_TICKHI_LSB +: 2];
            end
            if (wr_sh) begin
                lead_r.tx_lead_ticks[6:0] <= pwdata[txr_pkg::SH_TICKLO_LSB +: 7];
                sh_other_r                <= {6'h00, pwdata[0]};
            end
        end
    end

    // beacon control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsec_r  <= 1'b0;
            btrig_r <= 1'b0;
        end else begin
            if (wr_bc) bsec_r <= pwdata[txr_pkg::BC_SEC_BIT];
            btrig_r <= wr_bc & pwdata[txr_pkg::TRIG_BIT];
        end
    end

    // normal control, retransmission and ack status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ntrig_r        <= 1'b0;
            nopt_r         <= '0;
            fp_r           <= 1'b0;
            retry_r        <= 4'h0;
            awaiting_ack_r <= 1'b0;
            resend_r       <= 1'b0;
        end else begin
            ntrig_r  <= new_ntrig;
            resend_r <= 1'b0;
            if (wr_nc) begin
                nopt_r.ind <= pwdata[txr_pkg::NC_IND_BIT];
                nopt_r.ack <= pwdata[txr_pkg::NC_ACK_BIT];
                nopt_r.sec <= pwdata[txr_pkg::NC_SEC_BIT];
            end
            if (ntrig_r) begin
                nopt_r         <= '0;
                awaiting_ack_r <= nopt_r.ack;
                retry_r        <= 4'h0;
            end
            if (ack_seen) fp_r <= ack_frame_pending;
            if (awaiting_ack_r && ack_seen) begin
                awaiting_ack_r <= 1'b0;
            end else if (awaiting_ack_r && tx_done && !ntrig_r) begin
                if (retry_r < 4'(MAX_RETRIES)) begin
                    retry_r  <= retry_r + 4'h1;
                    resend_r <= 1'b1;
                end else begin
                    awaiting_ack_r <= 1'b0;
                end
            end
        end
    end

    // transmitter enable lead: count symbols plus ticks before packet start
    wire [19:0] lead_total = 20'(lead_r.tx_lead_symbols * txr_pkg::SYM_CYC)
                           + 20'(lead_r.tx_lead_ticks * txr_pkg::TICK_CYC);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lead_cnt_r <= 20'h00000;
            txen_r     <= 1'b0;
        end else if (beacon_send || normal_send) begin
            lead_cnt_r <= lead_total;
            txen_r     <= 1'b1;
        end else if (txen_r && (packet_due || tx_done)) begin
            txen_r     <= ~tx_done;
            lead_cnt_r <= 20'h00000;
        end else if (lead_cnt_r != 20'h00000) begin
            lead_cnt_r <= lead_cnt_r - 20'h00001;
        end
    end

    // send strobes go out one cycle after the trigger register; the lead count is loaded on the strobe
    logic bsend_pend_r;
    logic nsend_pend_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsend_pend_r <= 1'b0;
            nsend_pend_r <= 1'b0;
        end else begin
            bsend_pend_r <= btrig_r;
            nsend_pend_r <= ntrig_r | resend_r;
        end
    end

    assign beacon_send   = bsend_pend_r;
    assign normal_send   = nsend_pend_r;
    assign normal_opts   = nopt_r;
    assign beacon_secure = bsec_r;
    assign tx_enable     = txen_r;
    assign queue_enable  = lead_r.queue_enable;

    a_qen_reset: assert property (
        @(posedge pclk) $rose(presetn) |-> lead_r.queue_enable)
        else $error("queue enable not one after reset");

    a_qen_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_on |=> queue_enable == $past(pwdata[txr_pkg::ON_QEN_BIT]))
        else $error("queue enable write lost");

    a_sym_min: assert property (
        @(posedge pclk) disable iff (!presetn)
        lead_r.tx_lead_symbols >= txr_pkg::SYM_MIN)
        else $error("symbol lead below minimum");

    a_sym_clamp: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_on && sym_wr == 4'h0) |=> lead_r.tx_lead_symbols == txr_pkg::SYM_MIN)
        else $error("zero symbol lead not clamped");

    a_sym_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_on && sym_wr != 4'h0) |=> lead_r.tx_lead_symbols == $past(sym_wr))
        else $error("symbol lead write lost");

    a_tick_reset: assert property (
        @(posedge pclk) $rose(presetn) |-> lead_r.tx_lead_ticks == txr_pkg::TICK_RESET)
        else $error("tick lead reset wrong");

    a_tick_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_on |=> lead_r.tx_lead_ticks[8:7] == $past(pwdata[txr_pkg::ON_TICKHI_LSB +: 2]))
        else $error("tick high split wrong");

    a_tick_split: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_sh |=> lead_r.tx_lead_ticks[6:0] == $past(pwdata[txr_pkg::SH_TICKLO_LSB +: 7]))
        else $error("tick split wrong");

    a_bc_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_bc) |=> prdata[7:2] == 6'h00 && !prdata[0])
        else $error("beacon reserved bits nonzero");

    a_unmapped_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && !mapped) |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_bsec_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_bc |=> beacon_secure == $past(pwdata[txr_pkg::BC_SEC_BIT]))
        else $error("beacon security write lost");

    a_btrig_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        btrig_r |=> !btrig_r || $past(wr_bc))
        else $error("beacon trigger stuck");

    a_beacon_send: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_bc && pwdata[txr_pkg::TRIG_BIT]) |-> ##2 beacon_send)
        else $error("beacon send missing");

    a_beacon_once: assert property (
        @(posedge pclk) disable iff (!presetn)
        beacon_send |=> !beacon_send)
        else $error("beacon send longer than one cycle");

    a_normal_send: assert property (
        @(posedge pclk) disable iff (!presetn)
        new_ntrig |-> ##2 normal_send)
        else $error("normal send missing");

    a_ntrig_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        ntrig_r |=> !ntrig_r || $past(wr_nc))
        else $error("normal trigger stuck");

    a_opts_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ntrig_r && !wr_nc) |=> nopt_r == '0)
        else $error("options not cleared");

    a_resend: assert property (
        @(posedge pclk) disable iff (!presetn)
        (awaiting_ack_r && tx_done && !ack_seen && !ntrig_r && retry_r < 4'(MAX_RETRIES))
        |-> ##2 normal_send)
        else $error("retransmission missing");

    a_retry_limit: assert property (
        @(posedge pclk) disable iff (!presetn)
        retry_r <= 4'(MAX_RETRIES))
        else $error("retry count above limit");

    a_ack_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (awaiting_ack_r && ack_seen && !ntrig_r) |=> !awaiting_ack_r)
        else $error("ack did not end waiting");

    a_fp_track: assert property (
        @(posedge pclk) disable iff (!presetn)
        ack_seen |=> fp_r == $past(ack_frame_pending))
        else $error("pending status wrong");

    a_lead_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        (beacon_send && !packet_due) |=> lead_cnt_r == $past(lead_total) && tx_enable)
        else $error("lead count not loaded");

    a_lead_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        (lead_cnt_r != 20'h00000 && !beacon_send && !normal_send && !packet_due && !tx_done)
        |=> lead_cnt_r == $past(lead_cnt_r) - 20'h00001)
        else $error("lead count not running");

    a_txen_drop: assert property (
        @(posedge pclk) disable iff (!presetn)
        (txen_r && tx_done && !beacon_send && !normal_send) |=> !tx_enable)
        else $error("transmitter enable not dropped");

    a_prdata_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside setup");
endmodule : txr_regs

//--- src/txr_pkg.sv
// package: register map, field layout, reset values and timing constants
package txr_pkg;
    // byte addresses (printed offsets are word indices, so index * 4)
    localparam logic [7:0]  IDX_ON_TIME      = 8'h18;
    localparam logic [7:0]  IDX_SYMTICK_HIGH = 8'h14;
    localparam logic [7:0]  IDX_BEACON       = 8'h1A;
    localparam logic [7:0]  IDX_NORMAL       = 8'h1B;
    localparam logic [7:0]  IDX_STATUS       = 8'h1C;
    localparam logic [11:0] ADDR_ON_TIME      = {2'h0, IDX_ON_TIME, 2'h0};
    localparam logic [11:0] ADDR_SYMTICK_HIGH = {2'h0, IDX_SYMTICK_HIGH, 2'h0};
    localparam logic [11:0] ADDR_BEACON       = {2'h0, IDX_BEACON, 2'h0};
    localparam logic [11:0] ADDR_NORMAL       = {2'h0, IDX_NORMAL, 2'h0};
    localparam logic [11:0] ADDR_STATUS       = {2'h0, IDX_STATUS, 2'h0};

    // on-time register fields
    localparam int ON_QEN_BIT    = 7;
    localparam int ON_SYM_LSB    = 2;
    localparam int ON_TICKHI_LSB = 0;
    // symbol tick high register: lead ticks <6:0> at bits 7:1
    localparam int SH_TICKLO_LSB = 1;
    // beacon and normal control fields
    localparam int BC_SEC_BIT  = 1;
    localparam int TRIG_BIT    = 0;
    localparam int NC_SEC_BIT  = 1;
    localparam int NC_ACK_BIT  = 2;
    localparam int NC_IND_BIT  = 3;
    localparam int NC_FP_BIT   = 4;

    // reset values and symbol lead minimum
    localparam logic [3:0] SYM_RESET  = 4'h2;
    localparam logic [3:0] SYM_MIN    = 4'h1;
    localparam logic [8:0] TICK_RESET = 9'h028;
    localparam logic [7:0] SH_OTHER_RESET = 8'h00;

    // timing
    localparam int CLK_NS      = 25;
    localparam int SYMBOL_NS   = 16000;
    localparam int TICK_NS     = 50;
    localparam int SYM_CYC     = SYMBOL_NS / CLK_NS;
    localparam int TICK_CYC    = TICK_NS / CLK_NS;

    typedef struct packed {
        logic       queue_enable;
        logic [3:0] tx_lead_symbols;
        logic [8:0] tx_lead_ticks;
    } txr_lead_type;

    typedef struct packed {
        logic ind;
        logic ack;
        logic sec;
    } txr_frame_opt_type;
endpackage : txr_pkg

//--- sim/txr_regs_tb.sv
// self-checking bench for the transmit lead time and send control registers
`timescale 1ns/1ps
module txr_regs_tb;
    localparam logic [31:0] ON_RST = {24'h0, 2'h2, txr_pkg::SYM_RESET, txr_pkg::TICK_RESET[8:7]};
    localparam logic [31:0] SH_RST = {24'h0, txr_pkg::TICK_RESET[6:0], 1'b0};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_done = 1'b0;
    logic        ack_seen = 1'b0;
    logic        ack_pend = 1'b0;
    logic        beacon_send;
    logic        normal_send;
    logic        beacon_secure;
    logic        tx_enable;
    logic        queue_enable;
    logic [31:0] rd;
    logic        slverr_seen;
    int          errors = 0;
    int          checks_done = 0;
    int          n_bc = 0;
    int          n_nm = 0;
    txr_pkg::txr_frame_opt_type normal_opts;

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (beacon_send === 1'b1) n_bc <= n_bc + 1;
        if (normal_send === 1'b1) n_nm <= n_nm + 1;
    end

    txr_regs u_txr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .packet_due(1'b0), .tx_done(tx_done), .ack_seen(ack_seen),
        .ack_frame_pending(ack_pend), .beacon_send(beacon_send), .normal_send(normal_send),
        .normal_opts(normal_opts), .beacon_secure(beacon_secure), .tx_enable(tx_enable),
        .queue_enable(queue_enable));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : chk

    // one apb transfer; holds the request until pready is sampled high or 50 cycles pass
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        slverr_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    task automatic pulse_in(input int which, input int wait_cyc);
        @(posedge pclk);
        if (which == 0) tx_done <= 1'b1;
        else ack_seen <= 1'b1;
        @(posedge pclk);
        tx_done <= 1'b0;
        ack_seen <= 1'b0;
        repeat (wait_cyc) @(posedge pclk);
    endtask : pulse_in

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial begin
        #300000;
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, queue_enable}, 32'h1);
        rd_chk(txr_pkg::ADDR_ON_TIME, ON_RST);
        rd_chk(txr_pkg::ADDR_SYMTICK_HIGH, SH_RST);
        rd_chk(txr_pkg::ADDR_BEACON, 32'h0);
        $display("test reset values done");
        apb(1'b1, txr_pkg::ADDR_ON_TIME, 32'hFFFF_FF9B);
        rd_chk(txr_pkg::ADDR_ON_TIME, 32'h9B);
        apb(1'b1, txr_pkg::ADDR_SYMTICK_HIGH, 32'hA4);
        rd_chk(txr_pkg::ADDR_SYMTICK_HIGH, 32'hA4);
        apb(1'b1, txr_pkg::ADDR_ON_TIME, 32'h80);
        rd_chk(txr_pkg::ADDR_ON_TIME, 32'h84);
        $display("test lead time fields done");
        apb(1'b1, txr_pkg::ADDR_BEACON, 32'h02);
        chk({31'h0, beacon_secure}, 32'h1);
        apb(1'b1, txr_pkg::ADDR_BEACON, 32'h03);
        repeat (5) @(posedge pclk);
        chk(n_bc, 32'h1);
        rd_chk(txr_pkg::ADDR_BEACON, 32'h02);
        apb(1'b1, txr_pkg::ADDR_BEACON, 32'h00);
        chk({31'h0, beacon_secure}, 32'h0);
        $display("test beacon control done");
        apb(1'b1, txr_pkg::ADDR_NORMAL, 32'h0E);
        chk({29'h0, normal_opts}, 32'h7);
        apb(1'b1, txr_pkg::ADDR_NORMAL, 32'h0F);
        repeat (5) @(posedge pclk);
        chk(n_nm, 32'h1);
        chk({31'h0, tx_enable}, 32'h1);
        rd_chk(txr_pkg::ADDR_NORMAL, 32'h0);
        apb(1'b1, txr_pkg::ADDR_NORMAL, 32'h04);
        apb(1'b1, txr_pkg::ADDR_NORMAL, 32'h05);
        repeat (5) @(posedge pclk);
        chk(n_nm, 32'h2);
        pulse_in(0, 6);
        chk(n_nm, 32'h3);
        ack_pend <= 1'b1;
        pulse_in(1, 2);
        pulse_in(0, 6);
        chk(n_nm, 32'h3);
        chk({31'h0, tx_enable}, 32'h0);
        rd_chk(txr_pkg::ADDR_NORMAL, 32'h10);
        $display("test normal send and retry done");
        apb(1'b1, 12'h004, 32'hFF);
        chk({31'h0, slverr_seen}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        rd_chk(12'h004, 32'h0);
        $display("test unmapped access done");
        report_and_stop();
    end
endmodule : txr_regs_tb
